// *** rtl/optg_gen.sv ***
// optg_gen: transmit test pattern generator and low power idle power control
//
// Summary of operation
// R1 - mode one: 2-PAM square wave at rate/20
// R2 - mode one: scale 255, coding and precoder bypassed
// R3 - mode two: pseudo-random M-PAM, table scale, no precoder
// R4 - mode two: encapsulator cut off, no framing
// R5 - mode two: zero-fed scrambler, seeded, free running
// R6 - mode two: mapper widths log2(M), or 4/3
// R7 - mode two: two-dimensional symbols serialized at full rate
// R8 - mode two: low power idle disabled; code only forces light on, receive sleep still follows rx_idle_seen
// R9 - controller picks PAM levels via bit density
// R10 - mode three: toggle extremes every symbol clock
// R11 - mode three: scale 255, coding mostly bypassed
// R12 - mode four: mode two pattern at rate/10
// R13 - positive sample gives highest light power
// R14 - light power request switches transmitter off/on
// R15 - receive conversion power request on idle
// R16 - header advertises low power idle support
// R17 - light off after last zero symbol sent
// R18 - light on before first zero symbol
// R19 - one mode at a time, else normal path
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "optg_params.svh"

module optg_gen (
   input  wire logic                 pclk,          // symbol clock
   input  wire logic                 presetn,       // async reset, low
   input  wire logic                 psel,          // apb select
   input  wire logic                 penable,       // apb access phase
   input  wire logic                 pwrite,        // apb direction
   input  wire logic [11:0]          paddr,         // apb byte address
   input  wire logic [31:0]          pwdata,        // apb write data
   output logic      [31:0]          prdata,        // apb read data
   output logic                      pready,        // apb ready
   output logic                      pslverr,       // apb error
   input  wire logic [7:0]           norm_sample,   // normal path sample
   input  wire logic                 norm_payload_off, // normal path dark symbol
   input  wire logic                 rx_idle_seen,  // receive saw dark payload
   output optg_pkg::optg_tx_s        tx_out,        // to electro-optical unit
   output logic                      hdr_lpi_cap    // header capability bit
);

   // apb signals
   logic              acc;          // access phase
   logic              wr_en;        // write strobe
   // registers
   logic [2:0]        mode_sel_reg; // 0 normal, 1..4 test modes
   logic [2:0]        mbits_reg;    // bits per symbol, log2(M)
   logic              lpi_en_reg;   // allow low power idle
   logic              rx_sleep_reg; // allow receive sleep
   logic [7:0]        sf_reg [1:4]; // per-M scale table
   logic [3:0]        dly_reg;      // off pipeline delay
   logic [3:0]        wake_reg;     // second off delay tap, light waits for the longer of this and dly_reg
   // datapath state
   optg_pkg::optg_mode_e mode_reg;  // decoded one-hot mode
   optg_pkg::optg_mode_e mode_next;
   logic [14:0]       scr_reg;      // scrambler state
   logic [4:0]        tm1_cnt_reg;  // half period counter
   logic              pol_reg;      // square wave polarity
   logic [3:0]        div_cnt_reg;  // mode four divider
   logic              half_reg;     // mux phase: 0 first dim, 1 second
   logic [3:0]        q_reg;        // held second-dimension bits
   logic [15:0]       off_pipe_reg; // payload_off history
   logic [7:0]        sample_next;
   logic              step;         // advance pattern this cycle

   // apb: zero wait states, one access cycle
   // pready tied high, so no access can stall the symbol stream
   assign acc     = psel & penable;
   assign wr_en   = acc & pwrite;
   assign pready  = 1'b1;
   assign pslverr = acc & ~addr_ok(paddr);

   // known register addresses
   function automatic logic addr_ok(input logic [11:0] a);
      addr_ok = (a == `OPTG_ADDR_CTRL) || (a == `OPTG_ADDR_STATUS) ||
                (a == `OPTG_ADDR_SCALE) || (a == `OPTG_ADDR_DELAY);
   endfunction

   // scale a symbol by an 8-bit factor, keep top bits
   function automatic logic [7:0] scale(input logic [7:0] s, input logic [7:0] f);
      logic signed [16:0] p;
      p = $signed(s) * $signed({1'b0, f});
      scale = p[15:8];
   endfunction

   // map n bits to an odd-level signed PAM amplitude at full range
   function automatic logic [7:0] pam(input logic [3:0] b, input logic [2:0] n);
      logic [7:0] lvl;
      lvl = 8'h00;
      case (n)
         3'h1:    lvl = b[0] ? `OPTG_PAM_MAX : `OPTG_PAM_MIN;
         3'h2:    lvl = {b[1:0], 6'h20} ^ 8'h80;
         3'h3:    lvl = {b[2:0], 5'h10} ^ 8'h80;
         default: lvl = {b[3:0], 4'h8} ^ 8'h80;
      endcase
      pam = lvl;
   endfunction

   // every history bit from the newest up to tap n is dark
   function automatic logic run_dark(input logic [15:0] h, input logic [3:0] n);
      logic all_dark;
      all_dark = 1'b1;
      for (int k = 0; k <= 15; k++) begin
         if (k[3:0] <= n && !h[k]) begin
            all_dark = 1'b0;
         end
      end
      run_dark = all_dark;
   endfunction

   // control register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_sel_reg <= 3'h0;
         mbits_reg    <= `OPTG_MBITS_RST;
         lpi_en_reg   <= 1'b0;
         rx_sleep_reg <= 1'b0;
         dly_reg      <= `OPTG_DLY_RST;
         wake_reg     <= `OPTG_WAKE_RST;
      end else if (wr_en) begin
         if (paddr == `OPTG_ADDR_CTRL) begin
            // values beyond four fall back to normal, see R19
            mode_sel_reg <= (pwdata[2:0] > 3'h4) ? 3'h0 : pwdata[2:0];
            // bit density picks M, clamped to 1..4, see R9
            mbits_reg    <= (pwdata[6:4] == 3'h0) ? 3'h1 :
                            (pwdata[6:4] > 3'h4) ? 3'h4 : pwdata[6:4];
            lpi_en_reg   <= pwdata[8];
            rx_sleep_reg <= pwdata[9];
         end
         if (paddr == `OPTG_ADDR_DELAY) begin
            dly_reg  <= pwdata[3:0];
            wake_reg <= pwdata[7:4];
         end
      end
   end

   // scale table, one byte per M setting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 1; i <= 4; i++) begin
            sf_reg[i] <= `OPTG_SCALE_FULL;
         end
      end else if (wr_en && paddr == `OPTG_ADDR_SCALE) begin
         sf_reg[1] <= pwdata[7:0];
         sf_reg[2] <= pwdata[15:8];
         sf_reg[3] <= pwdata[23:16];
         sf_reg[4] <= pwdata[31:24];
      end
   end

   // read mux, registered data path not needed at zero wait
   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         `OPTG_ADDR_CTRL:   prdata = {22'h0, rx_sleep_reg, lpi_en_reg, 1'b0, mbits_reg, 1'b0, mode_sel_reg};
         `OPTG_ADDR_STATUS: prdata = {24'h0, `OPTG_LPI_CAP, tx_out.rx_on, tx_out.light_on, mode_reg};
         `OPTG_ADDR_SCALE:  prdata = {sf_reg[4], sf_reg[3], sf_reg[2], sf_reg[1]};
         `OPTG_ADDR_DELAY:  prdata = {24'h0, wake_reg, dly_reg};
         default:           prdata = 32'h0000_0000;
      endcase
   end

   // one-hot mode decode, only one mode at a time, see R19
   always_comb begin
      case (mode_sel_reg)
         3'h1:    mode_next = optg_pkg::OPTG_TM1;
         3'h2:    mode_next = optg_pkg::OPTG_TM2;
         3'h3:    mode_next = optg_pkg::OPTG_TM3;
         3'h4:    mode_next = optg_pkg::OPTG_TM4;
         default: mode_next = optg_pkg::OPTG_NORMAL;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= optg_pkg::OPTG_NORMAL;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // mode four advances once every ten symbols, see R12
   // only the step slows, so mode four repeats the mode two sequence
   assign step = (mode_reg == optg_pkg::OPTG_TM2) ||
                 (mode_reg == optg_pkg::OPTG_TM4 && div_cnt_reg == 4'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_reg <= 4'h0;
      end else if (mode_reg != optg_pkg::OPTG_TM4 || div_cnt_reg == `OPTG_TM4_DIV) begin
         div_cnt_reg <= 4'h0;
      end else begin
         div_cnt_reg <= div_cnt_reg + 4'h1;
      end
   end

   // scrambler: zero input, reseeded on mode entry, then free running, see R5
   // encapsulator data never reaches it in test, see R4
   // reseeding on every mode change restarts the sequence at each test entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scr_reg <= `OPTG_SCR_SEED;
      end else if (mode_next != mode_reg) begin
         scr_reg <= `OPTG_SCR_SEED;
      end else if (step && !half_reg) begin
         // draw a full 2-D symbol worth of bits: shift 8 per symbol pair
         scr_reg <= {scr_reg[6:0], scr_reg[14:7] ^ scr_reg[13:6]};
      end
   end

   // symbol mux phase: first dimension then second, see R7
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_reg <= 1'b0;
         q_reg    <= 4'h0;
      end else if (mode_next != mode_reg) begin
         half_reg <= 1'b0;
         q_reg    <= 4'h0;
      end else if (step) begin
         half_reg <= ~half_reg;
         // second dimension takes 3 bits when M is 16, see R6
         q_reg    <= (mbits_reg == 3'h4) ? {1'b0, scr_reg[7:5]} : scr_reg[7:4];
      end
   end

   // square wave timing: mode one every 10, mode three every cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tm1_cnt_reg <= 5'h00;
         pol_reg     <= 1'b0;
      end else if (mode_reg == optg_pkg::OPTG_TM3) begin
         pol_reg     <= ~pol_reg; // see R10
         tm1_cnt_reg <= 5'h00;
      end else if (mode_reg == optg_pkg::OPTG_TM1) begin
         // ten high, ten low gives rate/20, see R1
         if (tm1_cnt_reg == `OPTG_TM1_HALF - 5'h01) begin
            tm1_cnt_reg <= 5'h00;
            pol_reg     <= ~pol_reg;
         end else begin
            tm1_cnt_reg <= tm1_cnt_reg + 5'h01;
         end
      end else begin
         tm1_cnt_reg <= 5'h00;
         pol_reg     <= 1'b0;
      end
   end

   // sample selection; no precoder or framing in any test mode
   always_comb begin
      sample_next = norm_sample; // normal path, see R19
      case (mode_reg)
         // extremes at full scale, bypassing coding, see R2 R11 R13
         optg_pkg::OPTG_TM1,
         optg_pkg::OPTG_TM3: sample_next = scale(pol_reg ? `OPTG_PAM_MAX : `OPTG_PAM_MIN,
                                                 `OPTG_SCALE_FULL);
         // mapper dims from scrambler bits with table scale, see R3 R6
         optg_pkg::OPTG_TM2,
         optg_pkg::OPTG_TM4: sample_next = scale(pam(half_reg ? q_reg : scr_reg[3:0], mbits_reg),
                                                 sf_reg[mbits_reg]);
         default:            sample_next = norm_sample;
      endcase
   end

   // output sample register; mode four holds between steps, see R12
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_out.sample <= 8'h00;
      end else if (mode_reg != optg_pkg::OPTG_TM4 || step) begin
         tx_out.sample <= sample_next;
      end
   end

   // history of dark-payload marks for delay alignment
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_pipe_reg <= 16'h0000;
      end else begin
         off_pipe_reg <= {off_pipe_reg[14:0], norm_payload_off};
      end
   end

   // light request: off after delay so last zero symbol goes out, see R17;
   // on in the cycle after the early mark clears, with no wake time lead, see R18.
   // the early tap is the input itself, so the longer of wake_reg and dly_reg sets the off delay margin.
   // a short lit gap restarts the run, so zeros still in flight keep the light on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_out.light_on <= 1'b1;
      end else if (mode_reg != optg_pkg::OPTG_NORMAL || !lpi_en_reg) begin
         tx_out.light_on <= 1'b1; // test modes keep light on, see R8
      end else if (!norm_payload_off) begin
         tx_out.light_on <= 1'b1; // see R18 R14
      end else if (run_dark(off_pipe_reg, dly_reg) && run_dark(off_pipe_reg, wake_reg)) begin
         tx_out.light_on <= 1'b0; // see R17 R14
      end
   end

   // receive conversion sleeps while dark payload is seen, see R15
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_out.rx_on <= 1'b1;
      end else begin
         tx_out.rx_on <= ~(rx_sleep_reg & lpi_en_reg & rx_idle_seen);
      end
   end

   // header capability bit, see R16
   assign hdr_lpi_cap = `OPTG_LPI_CAP;

endmodule
`default_nettype wire

// *** inc/optg_params.svh ***
// optg constants: modes, scale, timing, register map
`ifndef OPTG_PARAMS_SVH
`define OPTG_PARAMS_SVH
`define OPTG_ADDR_CTRL      12'h000
`define OPTG_ADDR_STATUS    12'h004
`define OPTG_ADDR_SCALE     12'h008
`define OPTG_ADDR_DELAY     12'h00c
`define OPTG_SCALE_FULL     8'hff
`define OPTG_TM1_HALF       5'h0a
`define OPTG_TM4_DIV        4'h9
`define OPTG_SCR_SEED       15'h7fff
`define OPTG_PAM_MAX        8'h7f
`define OPTG_PAM_MIN        8'h81
`define OPTG_DLY_RST        4'h4
`define OPTG_WAKE_RST       4'h8
`define OPTG_MBITS_RST      3'h1
`define OPTG_LPI_CAP        1'b1
`endif

// *** inc/optg_pkg.sv ***
// optg package: types shared by the pattern generator
package optg_pkg;
   typedef enum logic [4:0] {
      OPTG_NORMAL = 5'h01,
      OPTG_TM1    = 5'h02,
      OPTG_TM2    = 5'h04,
      OPTG_TM3    = 5'h08,
      OPTG_TM4    = 5'h10
   } optg_mode_e;
   typedef struct packed {
      logic [7:0] sample;     // signed transmit sample
      logic       light_on;   // light power request, 1 = on
      logic       rx_on;      // rx conversion power request, 1 = on
   } optg_tx_s;
endpackage

// *** verification/optg_gen_asserts.sv ***
// checker: port-level properties of the pattern generator
`timescale 1ns/100ps
`default_nettype none
module optg_gen_asserts (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [11:0]        paddr,
   input wire logic [31:0]        pwdata,
   input wire logic               norm_payload_off,
   input wire logic [7:0]         norm_sample,
   input wire logic               rx_idle_seen,
   input wire optg_pkg::optg_tx_s tx_out,
   input wire logic               hdr_lpi_cap
);
   localparam logic [7:0] HI = 8'h7e; // +127 at scale 255
   localparam logic [7:0] LO = 8'h81; // -127 at scale 255
   logic [9:0] ctl_reg;  // shadow of control word
   logic [4:0] age_reg;  // cycles since control write
   logic [4:0] dark_reg; // run of dark marks
   wire logic [2:0] md = (ctl_reg[2:0] > 3'h4) ? 3'h0 : ctl_reg[2:0]; // bad codes mean normal
   wire logic ok = age_reg > 5'h03; // pipeline settled after mode change
   wire logic rxw = ctl_reg[9] && ctl_reg[8] && rx_idle_seen;
   wire logic [7:0] s = tx_out.sample;
   // shadow follows apb writes to the control word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg <= 10'h010;
         age_reg <= 5'h00;
      end else if (psel && penable && pwrite && paddr == 12'h000) begin
         ctl_reg <= pwdata[9:0];
         age_reg <= 5'h00;
      end else if (age_reg != 5'h1f) begin
         age_reg <= age_reg + 5'h01;
      end
   end
   // saturating run length, so long waits cannot wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         dark_reg <= 5'h00;
      else if (!norm_payload_off)
         dark_reg <= 5'h00;
      else if (dark_reg != 5'h1f)
         dark_reg <= dark_reg + 5'h01;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_CAP: assert property (hdr_lpi_cap) else $error("capability bit low");
   AST_TM1_LVL: assert property (ok && md == 3'h1 |-> s == HI || s == LO) else $error("mode one level");
   AST_TM1_HOLD: assert property (ok && md == 3'h1 && $changed(s) |=> ($stable(s) || !ok) [*8])
      else $error("mode one half too short");
   AST_TM3_TGL: assert property (ok && md == 3'h3 |-> $changed(s) && (s == HI || s == LO))
      else $error("mode three no toggle");
   AST_TM4_HOLD: assert property (ok && md == 3'h4 && $changed(s) |=> ($stable(s) || !ok) [*8])
      else $error("mode four too fast");
   AST_TEST_LIGHT: assert property (ok && md != 3'h0 |-> tx_out.light_on) else $error("light off in test");
   AST_NORMAL: assert property (ok && md == 3'h0 |-> s == $past(norm_sample)) else $error("normal path");
   // a run of 17 covers the longest tap of 15 plus history and output stages
   AST_DARK: assert property (ok && md == 3'h0 && ctl_reg[8] && dark_reg > 5'h10 |-> !tx_out.light_on)
      else $error("light stays on");
   AST_WAKE:
      assert property (ok && md == 3'h0 && ctl_reg[8] && $fell(norm_payload_off) |=> tx_out.light_on)
      else $error("late wake");
   AST_RX: assert property (ok && md == 3'h0 |=> tx_out.rx_on == !$past(rxw)) else $error("rx power");
   cover property (ok && md == 3'h1);
   cover property (ok && md == 3'h2);
   cover property (ok && ctl_reg[8] && $fell(norm_payload_off));
endmodule
bind optg_gen optg_gen_asserts u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .norm_payload_off(norm_payload_off), .norm_sample(norm_sample),
   .rx_idle_seen(rx_idle_seen), .tx_out(tx_out), .hdr_lpi_cap(hdr_lpi_cap));
`default_nettype wire

// *** verification/optg_eo_model.sv ***
// model of the electro-optical unit: light level at the fibre
`timescale 1ns/100ps
`default_nettype none
module optg_eo_model (
   input  wire logic               pclk,
   input  wire optg_pkg::optg_tx_s tx_in,
   output logic [7:0]              light_lvl
);
   // offset binary: most positive brightest, dark when request is off
   always_ff @(posedge pclk)
      light_lvl <= tx_in.light_on ? (tx_in.sample ^ 8'h80) : 8'h00;
endmodule
`default_nettype wire

// *** verification/optg_gen_tb.sv ***
// testbench: apb driver, read queue checker, optical model, mode sweep
`timescale 1ns/100ps
`default_nettype none
module optg_gen_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, n_off = 1'b0, rx_idle = 1'b0;
   logic [11:0]        paddr = 12'h000;
   logic [31:0]        pwdata = 32'h0, prdata, r;
   logic               pready, pslverr, cap;
   logic [7:0]         n_smp = 8'h00, lvl, hi, ex, ch, prv;
   optg_pkg::optg_tx_s tx;
   int                 bad_count, compares, cyc;
   logic [32:0]        exp_q[$]; // expected {pslverr, prdata} per read
   logic [9:0]         ctl_tab[5] = '{10'h111, 10'h113, 10'h112, 10'h142, 10'h144};
   optg_gen u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .norm_sample(n_smp), .norm_payload_off(n_off), .rx_idle_seen(rx_idle), .tx_out(tx), .hdr_lpi_cap(cap));
   optg_eo_model u_eo (.pclk(pclk), .tx_in(tx), .light_lvl(lvl));
   always #5 pclk = ~pclk; // 100 MHz
   task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // one apb transfer; reads leave their note for the monitor
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      if (!wr)
         exp_q.push_back(e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk); // idle cycle keeps strobes from double assignment
   endtask
   // read monitor: oldest note against each completed read
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite)
         chk("apb read", {pslverr, prdata}, exp_q.pop_front());
   // hang guard, well above the few hundred cycles needed
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      void'($urandom(60432));
      fork
         forever @(posedge pclk) n_smp <= 8'($urandom);
      join_none
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset values, unmapped place, read-only status, bad mode code
      apb(0, 12'h000, 0, 33'h0_0000_0010);
      apb(0, 12'h004, 0, 33'h0_0000_00e1);
      apb(0, 12'h008, 0, 33'h0_ffff_ffff);
      apb(0, 12'h00c, 0, 33'h0_0000_0084);
      apb(0, 12'h010, 0, 33'h1_0000_0000);
      apb(1, 12'h004, 0, 0);
      apb(0, 12'h004, 0, 33'h0_0000_00e1);
      r = $urandom;
      apb(1, 12'h008, r, 0);
      apb(0, 12'h008, 0, {1'b0, r});
      apb(1, 12'h00c, r, 0);
      apb(0, 12'h00c, 0, {25'h0, r[7:0]});
      apb(1, 12'h00c, 32'h84, 0); // back to reset delays for the idle timing
      chk("header capability", cap, 1'b1);
      apb(1, 12'h000, 32'h7, 0);
      apb(0, 12'h004, 0, 33'h0_0000_00e1);
      $display("registers done");
      // sweep test modes with dark marks pending; square modes see a random scale table
      n_off <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         if (i == 2)
            apb(1, 12'h008, 32'hffff_ffff, 0);
         apb(1, 12'h000, {22'h0, ctl_tab[i]}, 0);
         repeat (6) @(posedge pclk);
         apb(0, 12'h004, 0, {1'b0, 32'he0 | (32'h1 << ctl_tab[i][2:0])});
         hi = 8'h00;
         ex = 8'h00;
         ch = 8'h00;
         prv = tx.sample;
         repeat (40) begin
            @(posedge pclk);
            hi += (lvl == 8'hfe);
            ex += (lvl == 8'hfe || lvl == 8'h01);
            ch += (tx.sample !== prv);
            prv = tx.sample;
         end
         case (i)
            0: chk("mode one", {hi, ex, ch}, {8'h14, 8'h28, 8'h04});
            1: chk("mode three", {hi, ex, ch}, {8'h14, 8'h28, 8'h28});
            2: chk("mode two two-level", ex, 8'h28);
            3: chk("mode two many-level", ch > 8'h0a, 1'b1);
            default: chk("mode four", {ch != 8'h00, ch <= 8'h04}, 2'b11);
         endcase
         $display("mode entry %0d done", i);
      end
      // low power idle in normal mode, then wake
      apb(1, 12'h000, 32'h310, 0);
      rx_idle <= 1'b1;
      repeat (20) @(posedge pclk);
      chk("dark light", tx.light_on, 0);
      chk("rx sleep", tx.rx_on, 0);
      apb(0, 12'h004, 0, 33'h0_0000_0081);
      n_off <= 1'b0;
      rx_idle <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("wake light", tx.light_on, 1);
      // short lit gap, then dark again: light must wait for the delay taps
      n_off <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("light held", tx.light_on, 1);
      repeat (12) @(posedge pclk);
      chk("light off again", tx.light_on, 0);
      $display("idle done");
      give_verdict();
   end
endmodule
`default_nettype wire
